// *** rtl/blm_map.svh ***
// Register offsets, field positions, reset values and timing for the black level monitor
// Function
// - Measure residual offset at converter output and servo 10-bit offset DAC toward zero.
// - With compensation enabled, run one compensation pass every line after sync trailing edge.
// - With coast-clamp bit zero, skip compensation passes while the sample PLL coasts.
// - Wait the programmed pixel count after sync trailing edge before sampling black.
// - Average the selected number of pixels and add it into the accumulator.
// - Average over the selected number of lines and derive the 10-bit DAC code.
// - With compensation on, user offset is an 8-bit digital adder, one LSB per step.
// - DAC step is a quarter LSB, or an eighth LSB with range bit set.
// - With compensation off, DAC takes channel offset plus two low bits.
// - Pixel clock equals line sync frequency times programmed line total.
// - Offer 64 sampling phases per pixel, chosen by the phase register.
// - Glitch filter ignores line sync transitions within 100 ns of an accepted edge.
// - Continuously report sync activity and polarity for all three sync inputs.
// - Luma sync activity needs 64 consecutive pulses of equal period and duty.
// - With compensation on, channel offsets are added or subtracted digitally.
// - Range bit halves the total DAC swing in both modes.
`ifndef BLM_MAP_SVH
`define BLM_MAP_SVH
`define BLM_IDX_STAT      6'h01
`define BLM_IDX_POL       6'h02
`define BLM_IDX_LUMA      6'h04
`define BLM_IDX_INCFG     6'h05
`define BLM_IDX_OFS_A     6'h09
`define BLM_IDX_OFS_B     6'h0a
`define BLM_IDX_OFS_C     6'h0b
`define BLM_IDX_OFS_LO    6'h0c
`define BLM_IDX_LT_A      6'h0e
`define BLM_IDX_LT_B      6'h0f
`define BLM_IDX_PHASE     6'h10
`define BLM_IDX_DLY_A     6'h14
`define BLM_IDX_DLY_B     6'h15
`define BLM_IDX_LOOP      6'h17
`define BLM_BIT_LOOP_OFF  0
`define BLM_BIT_RANGE     0
`define BLM_BIT_COAST_OK  5
`define BLM_RST_LUMA      8'h10
`define BLM_RST_ZERO      8'h00
`define BLM_GLITCH_NS     100
`define BLM_CLK_NS        20
`define BLM_LUMA_RUN      7'h40
`define BLM_RESP_OK       2'h0
`define BLM_RESP_ERR      2'h2
`endif

// *** rtl/blm_pkg.sv ***
// Types shared by the black level and sync monitor
package blm_pkg;
  typedef logic [2:0][7:0] pix3_t;
  typedef logic [2:0][9:0] dac3_t;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_SAMPLE, ST_UPDATE} black_level_loop_state_e;
  typedef struct packed {
    logic [7:0]      luma_setup;
    logic [7:0]      in_cfg;
    logic [2:0][7:0] ofs;
    logic [7:0]      ofs_lo;
    logic [7:0]      lt_a;
    logic [7:0]      lt_b;
    logic [7:0]      phase;
    logic [7:0]      dly_a;
    logic [7:0]      dly_b;
    logic [7:0]      loop;
  } cfg_s;
endpackage

// *** rtl/black_level_and_sync_monitor.sv ***
// Black level servo, sync glitch filter and sync monitor with AXI4-Lite registers
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
`include "blm_map.svh"
module black_level_and_sync_monitor import blm_pkg::*; #(
  parameter int         ACT_TIMEOUT  = 65535,
  parameter int         PER_TOL      = 2,
  parameter logic [7:0] BLACK_TARGET = 8'h00
) (
  input  wire logic        i_mclk,
  input  wire logic        i_resetn,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  input  wire logic        i_hsync,
  input  wire logic        i_vsync,
  input  wire logic        i_luma_slice,
  input  wire logic        i_pll_coast,
  input  wire pix3_t       i_pix,
  output pix3_t            o_pix,
  output dac3_t            o_offset_dac,
  output logic             o_dac_half_range,
  output logic [15:0]      o_line_total,
  output logic [5:0]       o_sample_phase,
  output logic [7:0]       o_luma_setup,
  output logic             o_hsync_filt
);
  localparam int GLITCH_RAW = `BLM_GLITCH_NS / `BLM_CLK_NS;
  localparam int GLITCH_INT = (GLITCH_RAW < 1) ? 1 : GLITCH_RAW;
  localparam logic [2:0] GLITCH_CYC = 3'(GLITCH_INT);
  localparam logic [15:0] ACT_LIM = 16'(ACT_TIMEOUT);

  function automatic logic [7:0] shr8(input logic [14:0] v, input logic [2:0] sh);
    logic [14:0] t;
    t = v >> sh;
    return t[7:0];
  endfunction

  function automatic logic close(input logic [15:0] a, input logic [15:0] b);
    logic [15:0] d;
    d = (a > b) ? a - b : b - a;
    return d <= 16'(PER_TOL);
  endfunction

  function automatic logic [15:0] inc16(input logic [15:0] v);
    return (v == 16'hffff) ? v : v + 16'h0001;
  endfunction

  function automatic logic [7:0] add_ofs(input logic [7:0] p, input logic [7:0] o);
    logic signed [9:0] s;
    s = $signed({2'b00, p}) + $signed({{2{o[7]}}, o});
    if (s > 10'sd255) return 8'hff;
    if (s < 10'sd0) return 8'h00;
    return s[7:0];
  endfunction

  // Quarter or eighth LSB steps: one LSB of error is 4 or 8 DAC codes
  function automatic logic [9:0] servo(input logic [9:0] dac, input logic [7:0] avg,
                                       input logic rng);
    logic signed [9:0]  err;
    logic signed [13:0] v;
    err = $signed({2'b00, avg}) - $signed({2'b00, BLACK_TARGET});
    v = $signed({{4{dac[9]}}, dac}) - (rng ? (14'(err) <<< 3) : (14'(err) <<< 2));
    if (v > 14'sd511) return 10'h1ff;
    if (v < -14'sd512) return 10'h200;
    return v[9:0];
  endfunction

  //****************************************************************
  // Register bus
  //****************************************************************
  cfg_s        cfg_q, cfg_d;
  logic        awrdy_q, awrdy_d, bvalid_q, bvalid_d, arrdy_q, arrdy_d, rvalid_q, rvalid_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  logic [5:0]  widx, ridx;
  logic        wr_ok;
  logic [7:0]  stat_byte, pol_byte;

  assign widx = i_awaddr[7:2];
  assign ridx = i_araddr[7:2];
  assign wr_ok = (widx == `BLM_IDX_LUMA) || (widx == `BLM_IDX_INCFG) ||
                 (widx == `BLM_IDX_OFS_A) || (widx == `BLM_IDX_OFS_B) ||
                 (widx == `BLM_IDX_OFS_C) || (widx == `BLM_IDX_OFS_LO) ||
                 (widx == `BLM_IDX_LT_A) || (widx == `BLM_IDX_LT_B) ||
                 (widx == `BLM_IDX_PHASE) || (widx == `BLM_IDX_DLY_A) ||
                 (widx == `BLM_IDX_DLY_B) || (widx == `BLM_IDX_LOOP);

  always_comb begin
    awrdy_d  = i_awvalid && i_wvalid && !awrdy_q && !bvalid_q;
    bvalid_d = bvalid_q ? !i_bready : awrdy_q;
    bresp_d  = bresp_q;
    cfg_d    = cfg_q;
    if (awrdy_q) begin
      bresp_d = wr_ok ? `BLM_RESP_OK : `BLM_RESP_ERR;
      if (i_wstrb[0]) begin
        case (widx)
          `BLM_IDX_LUMA:   cfg_d.luma_setup = i_wdata[7:0];
          `BLM_IDX_INCFG:  cfg_d.in_cfg = i_wdata[7:0];
          `BLM_IDX_OFS_A:  cfg_d.ofs[0] = i_wdata[7:0];
          `BLM_IDX_OFS_B:  cfg_d.ofs[1] = i_wdata[7:0];
          `BLM_IDX_OFS_C:  cfg_d.ofs[2] = i_wdata[7:0];
          `BLM_IDX_OFS_LO: cfg_d.ofs_lo = i_wdata[7:0];
          `BLM_IDX_LT_A:   cfg_d.lt_a = i_wdata[7:0];
          `BLM_IDX_LT_B:   cfg_d.lt_b = i_wdata[7:0];
          `BLM_IDX_PHASE:  cfg_d.phase = i_wdata[7:0];
          `BLM_IDX_DLY_A:  cfg_d.dly_a = i_wdata[7:0];
          `BLM_IDX_DLY_B:  cfg_d.dly_b = i_wdata[7:0];
          `BLM_IDX_LOOP:   cfg_d.loop = i_wdata[7:0];
          default:         cfg_d = cfg_q;
        endcase
      end
    end
    arrdy_d  = i_arvalid && !arrdy_q && !rvalid_q;
    rvalid_d = rvalid_q ? !i_rready : arrdy_q;
    rdata_d  = rdata_q;
    rresp_d  = rresp_q;
    if (arrdy_q) begin
      rresp_d = `BLM_RESP_OK;
      case (ridx)
        `BLM_IDX_STAT:   rdata_d = {24'h0, stat_byte};
        `BLM_IDX_POL:    rdata_d = {24'h0, pol_byte};
        `BLM_IDX_LUMA:   rdata_d = {24'h0, cfg_q.luma_setup};
        `BLM_IDX_INCFG:  rdata_d = {24'h0, cfg_q.in_cfg};
        `BLM_IDX_OFS_A:  rdata_d = {24'h0, cfg_q.ofs[0]};
        `BLM_IDX_OFS_B:  rdata_d = {24'h0, cfg_q.ofs[1]};
        `BLM_IDX_OFS_C:  rdata_d = {24'h0, cfg_q.ofs[2]};
        `BLM_IDX_OFS_LO: rdata_d = {24'h0, cfg_q.ofs_lo};
        `BLM_IDX_LT_A:   rdata_d = {24'h0, cfg_q.lt_a};
        `BLM_IDX_LT_B:   rdata_d = {24'h0, cfg_q.lt_b};
        `BLM_IDX_PHASE:  rdata_d = {24'h0, cfg_q.phase};
        `BLM_IDX_DLY_A:  rdata_d = {24'h0, cfg_q.dly_a};
        `BLM_IDX_DLY_B:  rdata_d = {24'h0, cfg_q.dly_b};
        `BLM_IDX_LOOP:   rdata_d = {24'h0, cfg_q.loop};
        default: begin
          rdata_d = 32'h0;
          rresp_d = `BLM_RESP_ERR;
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg_q <= '{luma_setup: `BLM_RST_LUMA, in_cfg: `BLM_RST_ZERO, ofs: '0,
                 ofs_lo: `BLM_RST_ZERO, lt_a: `BLM_RST_ZERO, lt_b: `BLM_RST_ZERO,
                 phase: `BLM_RST_ZERO, dly_a: `BLM_RST_ZERO, dly_b: `BLM_RST_ZERO,
                 loop: `BLM_RST_ZERO};
      awrdy_q  <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q  <= `BLM_RESP_OK;
      arrdy_q  <= 1'b0;
      rvalid_q <= 1'b0;
      rresp_q  <= `BLM_RESP_OK;
      rdata_q  <= 32'h0;
    end else begin
      cfg_q    <= cfg_d;
      awrdy_q  <= awrdy_d;
      bvalid_q <= bvalid_d;
      bresp_q  <= bresp_d;
      arrdy_q  <= arrdy_d;
      rvalid_q <= rvalid_d;
      rresp_q  <= rresp_d;
      rdata_q  <= rdata_d;
    end
  end

  assign o_awready = awrdy_q;
  assign o_wready  = awrdy_q;
  assign o_bvalid  = bvalid_q;
  assign o_bresp   = bresp_q;
  assign o_arready = arrdy_q;
  assign o_rvalid  = rvalid_q;
  assign o_rresp   = rresp_q;
  assign o_rdata   = rdata_q;
  assign o_line_total     = {cfg_q.lt_a, cfg_q.lt_b};
  assign o_sample_phase   = cfg_q.phase[5:0];
  assign o_dac_half_range = cfg_q.ofs_lo[`BLM_BIT_RANGE];
  assign o_luma_setup     = cfg_q.luma_setup;

  //****************************************************************
  // Glitch filter and sync monitor
  //****************************************************************
  logic            hs_filt_q, hs_filt_d;
  logic [2:0]      gcnt_q, gcnt_d;
  logic [2:0]      s_in, prev_q, prev_d, pol_q, pol_d, act;
  logic [2:0][15:0] hi_q, hi_d, lo_q, lo_d, idle_q, idle_d, per_q, per_d, hw_q, hw_d;
  logic [2:0][6:0] run_q, run_d;
  logic [15:0]     cage_q, cage_d, apw;
  logic [1:0]      src;
  logic            trail, composite_sync;

  // Filter blinds itself after each accepted edge to reject ringing
  always_comb begin
    hs_filt_d = hs_filt_q;
    gcnt_d    = gcnt_q;
    if (gcnt_q != 3'h0) begin
      gcnt_d = gcnt_q - 3'h1;
    end else if (i_hsync != hs_filt_q) begin
      hs_filt_d = i_hsync;
      gcnt_d    = GLITCH_CYC;
    end
  end

  assign s_in = {i_luma_slice, i_vsync, hs_filt_q};
  assign src  = (cfg_q.in_cfg[4:3] == 2'h2) ? 2'd2 : 2'd0;

  always_comb begin
    prev_d = s_in;
    pol_d = pol_q;
    hi_d = hi_q;
    lo_d = lo_q;
    idle_d = idle_q;
    per_d = per_q;
    hw_d = hw_q;
    run_d = run_q;
    for (int k = 0; k < 3; k++) begin
      idle_d[k] = (s_in[k] != prev_q[k]) ? 16'h0 : inc16(idle_q[k]);
      if (s_in[k] && !prev_q[k]) begin
        per_d[k] = inc16(hi_q[k] + (lo_q[k] >> 1) + (lo_q[k] - (lo_q[k] >> 1)) - 16'h1);
        pol_d[k] = hi_q[k] > lo_q[k];
        hw_d[k]  = hi_q[k];
        hi_d[k]  = 16'h1;
        if (close(per_d[k], per_q[k]) && close(hi_q[k], hw_q[k])) begin
          run_d[k] = (run_q[k] == `BLM_LUMA_RUN) ? run_q[k] : run_q[k] + 7'h1;
        end else begin
          run_d[k] = 7'h0;
        end
      end else if (!s_in[k] && prev_q[k]) begin
        lo_d[k] = 16'h1;
      end else if (s_in[k]) begin
        hi_d[k] = inc16(hi_q[k]);
      end else begin
        lo_d[k] = inc16(lo_q[k]);
      end
      if (idle_q[k] >= ACT_LIM) run_d[k] = 7'h0;
    end
  end

  // Composite sync shows as an active pulse wider than a quarter line
  assign apw = pol_q[src] ? lo_q[src] : hi_q[src];
  always_comb begin
    cage_d = inc16(cage_q);
    if (cfg_q.in_cfg[4:3] != 2'h0 && per_q[src] != 16'h0 && apw > (per_q[src] >> 2)) begin
      cage_d = 16'h0;
    end
  end

  assign act[0] = idle_q[0] < ACT_LIM;
  assign act[1] = idle_q[1] < ACT_LIM;
  assign act[2] = (idle_q[2] < ACT_LIM) && (run_q[2] == `BLM_LUMA_RUN);
  assign composite_sync  = cage_q < ACT_LIM;
  assign stat_byte = {4'h0, composite_sync, act[2], act[1], act[0]};
  assign pol_byte  = {5'h0, pol_q};
  assign trail = pol_q[src] ? (s_in[src] && !prev_q[src]) : (!s_in[src] && prev_q[src]);

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      hs_filt_q <= 1'b0;
      gcnt_q    <= 3'h0;
      prev_q    <= 3'h0;
      pol_q     <= 3'h0;
      hi_q      <= '0;
      lo_q      <= '0;
      idle_q    <= {3{16'hffff}};
      per_q     <= '0;
      hw_q      <= '0;
      run_q     <= '0;
      cage_q    <= 16'hffff;
    end else begin
      hs_filt_q <= hs_filt_d;
      gcnt_q    <= gcnt_d;
      prev_q    <= prev_d;
      pol_q     <= pol_d;
      hi_q      <= hi_d;
      lo_q      <= lo_d;
      idle_q    <= idle_d;
      per_q     <= per_d;
      hw_q      <= hw_d;
      run_q     <= run_d;
      cage_q    <= cage_d;
    end
  end
  assign o_hsync_filt = hs_filt_q;

  //****************************************************************
  // Black level loop
  //****************************************************************
  black_level_loop_state_e      st_q, st_d;
  logic [15:0]      cnt_q, cnt_d, dly, npix_m1;
  logic [2:0][12:0] sum_q, sum_d;
  logic [2:0][14:0] lacc_q, lacc_d;
  logic [6:0]       lines_q, lines_d, lines_m1;
  dac3_t            dac_q, dac_d;
  pix3_t            pix_d, pix_q;
  logic             loop_on, coast_blk, last_line, rng;
  logic [2:0]       pshift, lshift;

  assign loop_on   = !cfg_q.loop[`BLM_BIT_LOOP_OFF];
  assign coast_blk = !cfg_q.in_cfg[`BLM_BIT_COAST_OK] && i_pll_coast;
  assign dly       = {cfg_q.dly_a, cfg_q.dly_b};
  assign pshift    = {1'b0, cfg_q.loop[3:2]} + 3'h2;
  assign npix_m1   = (16'h1 << pshift) - 16'h1;
  assign lshift    = cfg_q.loop[6:4];
  assign lines_m1  = 7'((8'h1 << lshift) - 8'h1);
  assign last_line = lines_q == lines_m1;
  assign rng       = cfg_q.ofs_lo[`BLM_BIT_RANGE];

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    sum_d = sum_q;
    lacc_d = lacc_q;
    lines_d = lines_q;
    dac_d = dac_q;
    case (st_q)
      ST_IDLE: if (trail && !coast_blk) begin
        cnt_d = dly;
        st_d  = ST_WAIT;
      end
      ST_WAIT: if (cnt_q == 16'h0) begin
        cnt_d = npix_m1;
        sum_d = '0;
        st_d  = ST_SAMPLE;
      end else begin
        cnt_d = cnt_q - 16'h1;
      end
      ST_SAMPLE: begin
        for (int k = 0; k < 3; k++) sum_d[k] = sum_q[k] + 13'(i_pix[k]);
        if (cnt_q == 16'h0) st_d = ST_UPDATE;
        else cnt_d = cnt_q - 16'h1;
      end
      ST_UPDATE: begin
        for (int k = 0; k < 3; k++) begin
          lacc_d[k] = lacc_q[k] + 15'(shr8({2'b00, sum_q[k]}, pshift));
          if (last_line) begin
            dac_d[k]  = servo(dac_q[k], shr8(lacc_d[k], lshift), rng);
            lacc_d[k] = '0;
          end
        end
        lines_d = last_line ? 7'h0 : lines_q + 7'h1;
        st_d = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
    if (!loop_on) begin
      st_d = ST_IDLE;
      lacc_d = '0;
      lines_d = 7'h0;
      for (int k = 0; k < 3; k++) begin
        dac_d[k] = {cfg_q.ofs[k], cfg_q.ofs_lo[7 - 2 * k -: 2]};
      end
    end
    for (int k = 0; k < 3; k++) begin
      pix_d[k] = loop_on ? add_ofs(i_pix[k], cfg_q.ofs[k]) : i_pix[k];
    end
  end

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_q    <= ST_IDLE;
      cnt_q   <= 16'h0;
      sum_q   <= '0;
      lacc_q  <= '0;
      lines_q <= 7'h0;
      dac_q   <= '0;
      pix_q   <= '0;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      sum_q   <= sum_d;
      lacc_q  <= lacc_d;
      lines_q <= lines_d;
      dac_q   <= dac_d;
      pix_q   <= pix_d;
    end
  end
  assign o_offset_dac = dac_q;
  assign o_pix        = pix_q;

  //****************************************************************
  // Assertions
  //****************************************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);

  a_glitch_blind: assert property ($changed(hs_filt_q) |=> $stable(hs_filt_q)[*5])
    else $error("line sync filter changed inside blind time");
  a_coast_skip: assert property (st_q == ST_IDLE && coast_blk |=> st_q == ST_IDLE)
    else $error("pass started while PLL coasting");
  a_pass_start: assert property (loop_on && st_q == ST_IDLE && trail && !coast_blk
                                 |=> st_q == ST_WAIT && cnt_q == $past(dly))
    else $error("pass not started on trailing edge");
  a_wait_done: assert property (loop_on && st_q == ST_WAIT && cnt_q == 16'h0
                                |=> st_q == ST_SAMPLE && cnt_q == $past(npix_m1))
    else $error("sampling did not follow the delay");
  a_sample_end: assert property (loop_on && st_q == ST_SAMPLE && cnt_q == 16'h0
                                 |=> st_q == ST_UPDATE ##1 st_q == ST_IDLE)
    else $error("sample window did not close");
  a_manual_dac: assert property (!loop_on |=> st_q == ST_IDLE &&
                                 dac_q[0] == {$past(cfg_q.ofs[0]), $past(cfg_q.ofs_lo[7:6])})
    else $error("manual offset not applied");
  a_digital_add: assert property (loop_on |=>
                                  o_pix[1] == add_ofs($past(i_pix[1]), $past(cfg_q.ofs[1])))
    else $error("digital offset adder wrong");
  a_luma_run: assert property (run_q[2] != $past(run_q[2]) |->
                               run_q[2] == 7'h0 || run_q[2] == $past(run_q[2]) + 7'h1)
    else $error("luma sync pulse run skipped a step");
  a_line_idle: assert property ($changed(hs_filt_q) |=> stat_byte[0])
    else $error("line sync edge not reported as activity");
  a_dac_hold: assert property (loop_on && st_q != ST_UPDATE |=> $stable(dac_q))
    else $error("offset DAC moved outside update");

  c_pass_done: cover property (loop_on && st_q == ST_UPDATE && last_line);
  c_luma_up: cover property ($rose(act[2]));
  c_composite_sync: cover property ($rose(composite_sync));
  c_coast: cover property (st_q == ST_IDLE && trail && coast_blk);
endmodule // black_level_and_sync_monitor
`default_nettype wire

// *** bench/blm_sync_src.sv ***
// Video sync source model driving line, frame and luma sync levels
`timescale 1ns/10ps
`default_nettype none
module blm_sync_src #(
  parameter int PER = 100,
  parameter int WID = 10
) (
  input  wire logic i_clk,
  input  wire logic i_en,
  input  wire logic i_glitch,
  output logic      o_hsync,
  output logic      o_vsync,
  output logic      o_luma
);
  // ****************************************
  // Fixed period and width pulses
  // ****************************************
  int hcnt = 0;
  int vcnt = 0;
  // Idle lines rest low; glitch mimics ringing just after the leading edge
  always @(posedge i_clk) begin
    hcnt <= (hcnt == PER - 1 || !i_en) ? 0 : hcnt + 1;
    vcnt <= (vcnt == 149 || !i_en) ? 0 : vcnt + 1;
    o_hsync <= i_en && hcnt < WID && !(i_glitch && hcnt == 2);
    o_vsync <= i_en && vcnt < 5;
    o_luma <= i_en && hcnt < WID;
  end
endmodule // blm_sync_src
`default_nettype wire

// *** bench/black_level_and_sync_monitor_tb.sv ***
// Self-checking bench for the black level and sync monitor
`timescale 1ns/10ps
`default_nettype none
`include "blm_map.svh"
module black_level_and_sync_monitor_tb import blm_pkg::*; ;
  // ****************************************
  // Stimulus, bus tasks and checks
  // ****************************************
  logic i_mclk = 0, i_resetn = 0, i_awvalid = 0, i_wvalid = 0, i_bready = 0;
  logic i_arvalid = 0, i_rready = 0, i_pll_coast = 0, en = 0, glitch = 0;
  logic [7:0] i_awaddr = 0, i_araddr = 0;
  logic [31:0] i_wdata = 0;
  logic [3:0] i_wstrb = 0;
  pix3_t i_pix = '0;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_dac_half_range;
  logic o_hsync_filt, i_hsync, i_vsync, i_luma_slice, fl = 0;
  logic [1:0] o_bresp, o_rresp;
  logic [31:0] o_rdata;
  pix3_t o_pix;
  dac3_t o_offset_dac, keep;
  logic [15:0] o_line_total;
  logic [5:0] o_sample_phase;
  logic [7:0] o_luma_setup;
  int errors = 0, num_checks = 0, cyc = 0, quiet = 9, flips = 0;
  always #10 i_mclk = ~i_mclk;
  black_level_and_sync_monitor #(.ACT_TIMEOUT(200)) u_dut (
    .i_mclk, .i_resetn, .i_awaddr, .i_awvalid, .o_awready, .i_wdata, .i_wstrb,
    .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready, .i_araddr, .i_arvalid,
    .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .i_hsync, .i_vsync,
    .i_luma_slice, .i_pll_coast, .i_pix, .o_pix, .o_offset_dac, .o_dac_half_range,
    .o_line_total, .o_sample_phase, .o_luma_setup, .o_hsync_filt);
  blm_sync_src u_src (.i_clk(i_mclk), .i_en(en), .i_glitch(glitch),
    .o_hsync(i_hsync), .o_vsync(i_vsync), .o_luma(i_luma_slice));
  task automatic end_of_test();
    if (errors == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er);
    i_awaddr <= {idx, 2'b00};
    i_wdata <= {24'h0, d};
    i_wstrb <= 4'h1;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    // Each channel is released on its own ready
    fork
      begin
        do @(posedge i_mclk); while (o_awready !== 1'b1);
        i_awvalid <= 1'b0;
      end
      begin
        do @(posedge i_mclk); while (o_wready !== 1'b1);
        i_wvalid <= 1'b0;
      end
    join
    i_bready <= 1'b1;
    do @(posedge i_mclk); while (o_bvalid !== 1'b1);
    i_bready <= 1'b0;
    chk(32'(o_bresp), 32'(er));
  endtask
  task automatic rd(input logic [5:0] idx, input logic [7:0] ed, input logic [7:0] m,
                    input logic [1:0] er);
    i_araddr <= {idx, 2'b00};
    i_arvalid <= 1'b1;
    do @(posedge i_mclk); while (o_arready !== 1'b1);
    i_arvalid <= 1'b0;
    i_rready <= 1'b1;
    do @(posedge i_mclk); while (o_rvalid !== 1'b1);
    i_rready <= 1'b0;
    chk(o_rdata & {24'h0, m}, {24'h0, ed});
    chk(32'(o_rresp), 32'(er));
  endtask
  task automatic lines(input int n);
    repeat (n * 100) @(posedge i_mclk);
  endtask
  // Filtered sync must rest at least the blind time between changes
  always @(posedge i_mclk) begin
    cyc++;
    quiet++;
    if (i_resetn && o_hsync_filt !== fl) begin
      chk(32'(quiet >= 5), 32'h1);
      quiet = 0;
      flips++;
    end
    fl = o_hsync_filt;
    if (cyc == 20000) begin
      errors++;
      end_of_test();
    end
  end
  initial begin
    repeat (4) @(posedge i_mclk);
    i_resetn <= 1'b1;
    @(posedge i_mclk);
    rd(`BLM_IDX_LUMA, `BLM_RST_LUMA, 8'hff, `BLM_RESP_OK);
    chk(32'(o_luma_setup), 32'(`BLM_RST_LUMA));
    rd(`BLM_IDX_LOOP, 8'h00, 8'hff, `BLM_RESP_OK);
    rd(6'h3f, 8'h00, 8'hff, `BLM_RESP_ERR);
    wr(`BLM_IDX_STAT, 8'h55, `BLM_RESP_ERR);
    wr(`BLM_IDX_LT_A, 8'h06, `BLM_RESP_OK);
    wr(`BLM_IDX_LT_B, 8'h9a, `BLM_RESP_OK);
    wr(`BLM_IDX_PHASE, 8'hc7, `BLM_RESP_OK);
    rd(`BLM_IDX_PHASE, 8'hc7, 8'hff, `BLM_RESP_OK);
    chk(32'(o_line_total), 32'h069a);
    chk(32'(o_sample_phase), 32'h07);
    // Channel b sits one step above black, so its code must fall
    i_pix <= {8'h00, 8'h01, 8'h00};
    en <= 1'b1;
    lines(75);
    rd(`BLM_IDX_STAT, 8'h07, 8'h0f, `BLM_RESP_OK);
    rd(`BLM_IDX_POL, 8'h00, 8'h07, `BLM_RESP_OK);
    chk(32'(o_offset_dac[0]), 32'h0);
    chk(32'(o_offset_dac[1][9]), 32'h1);
    chk(32'(o_offset_dac[1][1:0]), 32'h0);
    i_pll_coast <= 1'b1;
    lines(1);
    keep = o_offset_dac;
    lines(4);
    chk(32'(o_offset_dac), 32'(keep));
    i_pll_coast <= 1'b0;
    lines(4);
    chk(32'(o_offset_dac[1] !== keep[1]), 32'h1);
    // Separate syncs offered as composite must not raise the composite flag
    wr(`BLM_IDX_INCFG, 8'h08, `BLM_RESP_OK);
    lines(1);
    rd(`BLM_IDX_STAT, 8'h07, 8'h0f, `BLM_RESP_OK);
    glitch <= 1'b1;
    lines(10);
    glitch <= 1'b0;
    wr(`BLM_IDX_OFS_A, 8'h05, `BLM_RESP_OK);
    i_pix <= {8'h00, 8'h00, 8'h10};
    repeat (3) @(posedge i_mclk);
    chk(32'(o_pix[0]), 32'h15);
    wr(`BLM_IDX_OFS_A, 8'h7f, `BLM_RESP_OK);
    i_pix <= {8'h00, 8'h00, 8'hf0};
    repeat (3) @(posedge i_mclk);
    chk(32'(o_pix[0]), 32'hff);
    wr(`BLM_IDX_LOOP, 8'h01, `BLM_RESP_OK);
    wr(`BLM_IDX_OFS_LO, 8'hc1, `BLM_RESP_OK);
    repeat (3) @(posedge i_mclk);
    chk(32'(o_offset_dac[0]), 32'h1ff);
    chk(32'(o_offset_dac[1]), 32'h0);
    chk(32'(o_dac_half_range), 32'h1);
    chk(32'(o_pix[0]), 32'hf0);
    chk(32'(flips != 0), 32'h1);
    end_of_test();
  end
endmodule // black_level_and_sync_monitor_tb
`default_nettype wire
